//--- pkg/adc_ctrl_pkg.sv
// Constants, field layout and state codes of the SAR converter control block.
// Assumes an APB slave at 100 MHz; register indices are word numbers on the bus.
// Contract
// - SAR clock is the system clock divided by divider field plus one.
// - Three-bit gain field decodes to 1, 2, 4, 8, 16 or 0.5.
// - Enable low holds converter in shutdown; high lets it accept requests.
// - Busy reads one during a conversion, zero otherwise.
// - Busy falling sets the done flag and raises its request; here only when a conversion ends, not when a disable aborts it.
// - Done flag is only ever cleared by a software write of zero.
// - Busy write of zero does nothing; one starts only in start mode 00.
// - Start sources: busy write, timer A, pin rising edge, timer B.
// - Continuous tracking mode tracks whenever enabled and not converting.
// - Low-power tracking tracks three SAR clocks after start, then converts.
// - Low-power pin mode tracks while pin low, converts on rising edge.
// - Window flag sets on a matching result and stays until software clears.
// - Each result is compared with greater-than and less-than limit words.
// - Justify bit zero gives right-justified, one gives left-justified results.
// - Differential right-justified high byte holds top two bits, sign-extended above.
// - Single-ended right-justified high byte has upper six bits zero.
// - Left-justified: high byte eight top bits, low byte bits 7-6 the rest.
// - Left-justified low byte has its six lowest bits zero.
// - High-voltage amplifier enable bit switches that amplifier on and off.
// - Four-bit high-voltage gain code drives the amplifier gain setting.
// - Conversion is short enough for 100 ksps with a legal SAR clock.
package adc_ctrl_pkg;

	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_CONFIG = 8'hbc;
	localparam logic [7:0] IDX_RES_LO = 8'hbe;
	localparam logic [7:0] IDX_RES_HI = 8'hbf;
	localparam logic [7:0] IDX_HV_CTL = 8'hd6;
	localparam logic [7:0] IDX_CONV_CTL = 8'he8;

	// Reset values
	localparam logic [7:0] CONFIG_RESET = 8'hf8;
	localparam logic [7:0] CONV_CTL_RESET = 8'h00;
	localparam logic [7:0] HV_CTL_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// Field positions
	localparam int CFG_DIV_LSB = 3;
	localparam int CFG_GAIN_LSB = 0;
	localparam int CTL_EN_BIT = 7;
	localparam int CTL_TM_BIT = 6;
	localparam int CTL_DONE_BIT = 5;
	localparam int CTL_BUSY_BIT = 4;
	localparam int CTL_CM_LSB = 2;
	localparam int CTL_WIN_BIT = 1;
	localparam int CTL_LJ_BIT = 0;
	localparam int HV_EN_BIT = 7;
	localparam int HV_GAIN_LSB = 0;

	// Start-of-conversion mode codes
	localparam logic [1:0] CM_SOFTWARE = 2'h0;
	localparam logic [1:0] CM_TIMER_A = 2'h1;
	localparam logic [1:0] CM_EXT_PIN = 2'h2;
	localparam logic [1:0] CM_TIMER_B = 2'h3;

	// Timing
	localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;
	localparam logic [3:0] RESULT_MSB = 4'h9;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MAX_RATE_KSPS = 100;
	localparam int MIN_SAMPLE_PERIOD_NS = 1000000 / MAX_RATE_KSPS;
	localparam int MIN_SAMPLE_CYCLES = MIN_SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TRACK = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

endpackage

//--- hw/adc_conversion_control.sv
// SAR converter sequencing, result formatting, window detect and APB register file.
// Assumes timer overflows are one-cycle pulses on core_clk_in and the comparator
// bit is settled on core_clk_in when a SAR clock tick occurs.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module adc_conversion_control
	import adc_ctrl_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic timer_a_overflow_in,
	input wire logic timer_b_overflow_in,
	input wire logic external_convert_start_in,
	input wire logic comparator_in,
	input wire logic single_ended_in,
	input wire logic [15:0] greater_than_limit_in,
	input wire logic [15:0] less_than_limit_in,
	output logic converter_power_out,
	output logic track_out,
	output logic convert_active_out,
	output logic [9:0] sar_trial_out,
	output logic [5:0] pga_gain_sel_out,
	output logic hv_amp_enable_out,
	output logic [3:0] hv_amp_gain_out,
	output logic done_irq_req_out,
	output logic window_irq_req_out
);

	// Gain field to one-hot select: x1, x2, x4, x8, x16, x0.5
	function automatic logic [5:0] pga_decode(input logic [2:0] code);
		logic [5:0] sel;
		sel = 6'h00;
		unique casez (code)
			3'b000: sel = 6'h01;
			3'b001: sel = 6'h02;
			3'b010: sel = 6'h04;
			3'b011: sel = 6'h08;
			3'b10?: sel = 6'h10;
			3'b11?: sel = 6'h20;
		endcase
		return sel;
	endfunction

	// Place a 10-bit code into the result byte pair
	function automatic logic [15:0] format_result(input logic [9:0] code, input logic left,
		input logic single);
		logic [15:0] word;
		word = 16'h0000;
		if (left)
			word = {code, 6'h00};
		else if (single)
			word = {6'h00, code};
		else
			word = {{6{code[9]}}, code};
		return word;
	endfunction

	// Window test: limits in order give inside, reversed give outside
	function automatic logic window_match(input logic [15:0] word, input logic [15:0] gt,
		input logic [15:0] lt, input logic signed_mode);
		logic above;
		logic below;
		logic ordered;
		above = signed_mode ? ($signed(word) > $signed(gt)) : (word > gt);
		below = signed_mode ? ($signed(word) < $signed(lt)) : (word < lt);
		ordered = signed_mode ? ($signed(lt) > $signed(gt)) : (lt > gt);
		return ordered ? (above & below) : (above | below);
	endfunction

	logic [7:0] config_q;
	logic enable_q;
	logic track_mode_q;
	logic done_q;
	logic done_d;
	logic window_q;
	logic window_d;
	logic [1:0] start_mode_q;
	logic left_q;
	logic hv_en_q;
	logic [3:0] hv_gain_q;
	logic [7:0] res_hi_q;
	logic [7:0] res_lo_q;
	logic [31:0] prdata_q;
	logic [5:0] pga_sel_q;
	conv_state_t state_q;
	conv_state_t state_d;
	logic [4:0] div_cnt_q;
	logic [1:0] trk_cnt_q;
	logic [9:0] code_q;
	logic [9:0] code_d;
	logic [3:0] bit_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;

	// Bus decode
	wire logic [4:0] divider = config_q[CFG_DIV_LSB +: 5];
	wire logic [7:0] idx = paddr_in[9:2];
	wire logic word_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0);
	wire logic hit_cfg = word_ok && (idx == IDX_CONFIG);
	wire logic hit_lo = word_ok && (idx == IDX_RES_LO);
	wire logic hit_hi = word_ok && (idx == IDX_RES_HI);
	wire logic hit_hv = word_ok && (idx == IDX_HV_CTL);
	wire logic hit_ctl = word_ok && (idx == IDX_CONV_CTL);
	wire logic mapped = hit_cfg | hit_lo | hit_hi | hit_hv | hit_ctl;
	wire logic setup = psel_in & ~penable_in;
	wire logic access = psel_in & penable_in;
	wire logic wr_en = access & pwrite_in & pstrb_in[0];
	wire logic wr_cfg = wr_en & hit_cfg;
	wire logic wr_lo = wr_en & hit_lo;
	wire logic wr_hi = wr_en & hit_hi;
	wire logic wr_hv = wr_en & hit_hv;
	wire logic wr_ctl = wr_en & hit_ctl;

	// Converter status and start selection
	wire logic busy = (state_q != ST_IDLE);
	wire logic idle = (state_q == ST_IDLE);
	// Greater-or-equal also recovers a count left above a lowered divider
	wire logic sar_tick = (div_cnt_q >= divider);
	wire logic ext_rise = ext_s2_q & ~ext_s3_q;
	wire logic busy_wr = wr_ctl & pwdata_in[CTL_BUSY_BIT] & (start_mode_q == CM_SOFTWARE);
	wire logic src_evt = (start_mode_q == CM_SOFTWARE) ? busy_wr :
		(start_mode_q == CM_TIMER_A) ? timer_a_overflow_in :
		(start_mode_q == CM_EXT_PIN) ? ext_rise : timer_b_overflow_in;
	wire logic start_evt = enable_q & idle & src_evt;
	wire logic use_track = track_mode_q & (start_mode_q != CM_EXT_PIN);
	wire logic conv_end = enable_q & (state_q == ST_CONV) & sar_tick & (bit_q == 4'h0);
	wire logic [9:0] final_code = {code_q[9:1], comparator_in};
	wire logic [15:0] result_word = format_result(final_code, left_q, single_ended_in);
	wire logic win_hit = window_match(result_word, greater_than_limit_in,
		less_than_limit_in, ~single_ended_in);

	// Read mux
	wire logic [7:0] ctl_rd = {enable_q, track_mode_q, done_q, busy, start_mode_q,
		window_q, left_q};
	wire logic [7:0] hv_rd = {hv_en_q, 3'h0, hv_gain_q};
	wire logic [7:0] rd_mux = hit_cfg ? config_q : hit_lo ? res_lo_q : hit_hi ? res_hi_q :
		hit_hv ? hv_rd : hit_ctl ? ctl_rd : 8'h00;

	// Zero-wait slave; read data captured in the setup cycle
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~mapped;
	assign prdata_out = prdata_q;

	// Pin-facing and analog-facing outputs
	assign converter_power_out = enable_q;
	assign track_out = enable_q & ((idle & ~track_mode_q) | (state_q == ST_TRACK) |
		(idle & track_mode_q & (start_mode_q == CM_EXT_PIN) & ~ext_s2_q));
	assign convert_active_out = (state_q == ST_CONV);
	assign sar_trial_out = code_q;
	assign pga_gain_sel_out = pga_sel_q;
	assign hv_amp_enable_out = hv_en_q;
	assign hv_amp_gain_out = hv_gain_q;
	assign done_irq_req_out = done_q;
	assign window_irq_req_out = window_q;

	// Sticky flags: hardware set wins over a software clear
	assign done_d = conv_end | (wr_ctl ? pwdata_in[CTL_DONE_BIT] : done_q);
	assign window_d = (conv_end & win_hit) |
		(wr_ctl ? pwdata_in[CTL_WIN_BIT] : window_q);

	// Sequencer next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (start_evt)
					state_d = use_track ? ST_TRACK : ST_CONV;
			end
			ST_TRACK:
			begin
				if (sar_tick && (trk_cnt_q == TRACK_SAR_CLOCKS - 2'h1))
					state_d = ST_CONV;
			end
			ST_CONV:
			begin
				if (sar_tick && (bit_q == 4'h0))
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		if (!enable_q)
			state_d = ST_IDLE;
	end

	// Successive approximation step, MSB first
	always_comb
	begin
		code_d = code_q;
		if ((state_d == ST_CONV) && (state_q != ST_CONV))
			code_d = SAR_FIRST_TRIAL;
		else if ((state_q == ST_CONV) && sar_tick)
		begin
			code_d[bit_q] = comparator_in;
			if (bit_q != 4'h0)
				code_d[bit_q - 4'h1] = 1'b1;
		end
	end

	// Sequencer, divider and trial registers
	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			state_q <= ST_IDLE;
			div_cnt_q <= 5'h00;
			trk_cnt_q <= 2'h0;
			code_q <= 10'h000;
			bit_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			div_cnt_q <= sar_tick ? 5'h00 : div_cnt_q + 5'h01;
			code_q <= code_d;
			if (state_q != ST_TRACK)
				trk_cnt_q <= 2'h0;
			else if (sar_tick)
				trk_cnt_q <= trk_cnt_q + 2'h1;
			if ((state_d == ST_CONV) && (state_q != ST_CONV))
				bit_q <= RESULT_MSB;
			else if ((state_q == ST_CONV) && sar_tick && (bit_q != 4'h0))
				bit_q <= bit_q - 4'h1;
		end
	end

	// Convert-start pin synchroniser and edge history
	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			ext_s1_q <= 1'b1; // Pin idles high, so no false edge after reset
			ext_s2_q <= 1'b1;
			ext_s3_q <= 1'b1;
		end
		else
		begin
			ext_s1_q <= external_convert_start_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// Configuration and control registers
	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			config_q <= CONFIG_RESET;
			pga_sel_q <= pga_decode(CONFIG_RESET[2:0]);
			enable_q <= CONV_CTL_RESET[CTL_EN_BIT];
			track_mode_q <= CONV_CTL_RESET[CTL_TM_BIT];
			start_mode_q <= CONV_CTL_RESET[CTL_CM_LSB +: 2];
			left_q <= CONV_CTL_RESET[CTL_LJ_BIT];
			done_q <= CONV_CTL_RESET[CTL_DONE_BIT];
			window_q <= CONV_CTL_RESET[CTL_WIN_BIT];
			hv_en_q <= HV_CTL_RESET[HV_EN_BIT];
			hv_gain_q <= HV_CTL_RESET[HV_GAIN_LSB +: 4];
		end
		else
		begin
			if (wr_cfg)
				config_q <= pwdata_in[7:0];
			pga_sel_q <= pga_decode(config_q[CFG_GAIN_LSB +: 3]);
			if (wr_ctl)
			begin
				enable_q <= pwdata_in[CTL_EN_BIT];
				track_mode_q <= pwdata_in[CTL_TM_BIT];
				start_mode_q <= pwdata_in[CTL_CM_LSB +: 2];
				left_q <= pwdata_in[CTL_LJ_BIT];
			end
			done_q <= done_d;
			window_q <= window_d;
			if (wr_hv)
			begin
				hv_en_q <= pwdata_in[HV_EN_BIT];
				hv_gain_q <= pwdata_in[HV_GAIN_LSB +: 4];
			end
		end
	end

	// Result bytes and bus read data; a finished conversion wins over a write
	always_ff @(posedge core_clk_in)
	begin
		if (!resetn_in)
		begin
			res_hi_q <= RESULT_RESET;
			res_lo_q <= RESULT_RESET;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			if (conv_end)
			begin
				res_hi_q <= result_word[15:8];
				res_lo_q <= result_word[7:0];
			end
			else
			begin
				if (wr_hi)
					res_hi_q <= pwdata_in[7:0];
				if (wr_lo)
					res_lo_q <= pwdata_in[7:0];
			end
			if (setup && !pwrite_in)
				prdata_q <= {24'h00_0000, rd_mux};
		end
	end

	// Checks on sequencing and formatting
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	a_div_restart: assert property (sar_tick |=> div_cnt_q == 5'h00)
		else $error("divider did not restart after SAR tick");
	a_div_bound: assert property ($stable(divider) |-> div_cnt_q <= divider)
		else $error("divider count beyond divider field");
	a_gain_decode: assert property ($stable(config_q) |->
		pga_sel_q == pga_decode(config_q[2:0]))
		else $error("gain select does not follow field");
	a_shutdown_idle: assert property (!enable_q |-> !track_out ##1 idle)
		else $error("converter active while disabled");
	a_busy_read: assert property (access && hit_ctl && !pwrite_in |->
		prdata_out[CTL_BUSY_BIT] == $past(busy))
		else $error("busy bit read mismatch");
	a_done_on_fall: assert property ($fell(busy) && $past(enable_q) |-> done_q)
		else $error("done flag not set at end of conversion");
	a_done_sticky: assert property (done_q && !wr_ctl |=> done_q)
		else $error("done flag cleared by hardware");
	a_busy_wr_gate: assert property (idle && !start_evt |=> idle)
		else $error("conversion started without start event");
	a_track_three: assert property ($rose(state_q == ST_CONV) &&
		$past(state_q == ST_TRACK) |-> $past(sar_tick) &&
		$past(trk_cnt_q) == TRACK_SAR_CLOCKS - 2'h1)
		else $error("low-power tracking not three SAR clocks");
	a_sar_entry: assert property ($rose(state_q == ST_CONV) |->
		code_q == SAR_FIRST_TRIAL && bit_q == RESULT_MSB)
		else $error("conversion does not start at MSB");
	a_window_set: assert property (conv_end && win_hit |=> window_q)
		else $error("window flag not set on match");
	a_single_zero: assert property (conv_end && !left_q && single_ended_in |=>
		res_hi_q[7:2] == 6'h00)
		else $error("single-ended high byte not zero-filled");
	a_left_low: assert property (conv_end && left_q |=> res_lo_q[5:0] == 6'h00)
		else $error("left-justified low bits not zero");
	a_ignore_busy: assert property (!idle && src_evt |=> state_q != ST_IDLE || $past(conv_end)
		|| !$past(enable_q))
		else $error("start event disturbed running conversion");

	c_soft_conv: cover property (busy_wr && start_evt ##[1:300] conv_end);
	c_track_conv: cover property (state_q == ST_TRACK ##[1:300] conv_end);
	c_pin_conv: cover property (ext_rise && start_evt && track_mode_q ##[1:300] conv_end);
	c_window: cover property (conv_end && win_hit);

endmodule

//--- tb/adc_front_model.sv
// Far side model: comparator, timer overflow pulses and convert-start pin.
// Assumes the bench sets the input level and calls fire() from its thread.
`timescale 1ns/10ps
module adc_front_model
(
	input wire logic core_clk_in,
	input wire logic [9:0] sar_trial_in,
	input wire logic [9:0] level_in,
	output logic comparator_out,
	output logic timer_a_out,
	output logic timer_b_out,
	output logic ext_start_out
);
	// Keep the trial bit while the trial is not above the input level
	assign comparator_out = (sar_trial_in <= level_in);
	// Quiet start sources; the pin rests high on its pull-up
	initial
	begin
		timer_a_out = 1'b0;
		timer_b_out = 1'b0;
		ext_start_out = 1'b1;
	end
	// One start event from the chosen source
	task automatic fire(input logic [1:0] mode);
		@(posedge core_clk_in);
		timer_a_out <= (mode == 2'h1);
		timer_b_out <= (mode == 2'h3);
		ext_start_out <= (mode != 2'h2);
		@(posedge core_clk_in);
		timer_a_out <= 1'b0;
		timer_b_out <= 1'b0;
		repeat (20) @(posedge core_clk_in);
		ext_start_out <= 1'b1;
	endtask
endmodule

//--- tb/sar_adc_conversion_control_tb.sv
// Self-checking bench for the SAR converter control block over APB.
// Assumes zero-wait APB slave and the front model standing in for the analog side.
`timescale 1ns/10ps
module sar_adc_conversion_control_tb
	import adc_ctrl_pkg::*;
;
	logic core_clk_in, resetn_in, psel_in, penable_in, pwrite_in, single_ended;
	logic pready, pslverr, comp, tmr_a, tmr_b, ext_start, power, track, active;
	logic hv_en, done_irq, win_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, rnd;
	logic [3:0] pstrb, hv_gain;
	logic [15:0] gt_lim, lt_lim;
	logic [9:0] trial, level;
	logic [5:0] gsel;
	logic [33:0] notes[$];
	logic [33:0] note;
	int n_mismatch, compares, act_cnt, act_len, i;

	adc_conversion_control dut_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .timer_a_overflow_in(tmr_a),
		.timer_b_overflow_in(tmr_b), .external_convert_start_in(ext_start),
		.comparator_in(comp), .single_ended_in(single_ended),
		.greater_than_limit_in(gt_lim), .less_than_limit_in(lt_lim),
		.converter_power_out(power), .track_out(track), .convert_active_out(active),
		.sar_trial_out(trial), .pga_gain_sel_out(gsel), .hv_amp_enable_out(hv_en),
		.hv_amp_gain_out(hv_gain), .done_irq_req_out(done_irq),
		.window_irq_req_out(win_irq));
	adc_front_model front_u (.core_clk_in(core_clk_in), .sar_trial_in(trial),
		.level_in(level), .comparator_out(comp), .timer_a_out(tmr_a),
		.timer_b_out(tmr_b), .ext_start_out(ext_start));

	// Free-running 100 MHz clock
	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction
	task automatic fail(input string msg);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
		compares++;
		if (got !== exp)
			fail(msg);
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rq);
		int n;
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk_in);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rq = prdata;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (pready !== 1'b1)
		begin
			fail("no pready");
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rq;
		apb(1'b1, ba(idx), {24'h000000, d}, rq);
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic keep,
		output logic [31:0] rq);
		notes.push_back({keep, e});
		apb(1'b0, a, 32'h00000000, rq);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] rq;
		rd(ba(idx), {25'h0000000, e}, 1'b1, rq);
	endtask

	// Pair each finished read with the oldest note
	always @(posedge core_clk_in)
	begin
		if (psel_in && penable_in && pready === 1'b1 && !pwrite_in)
		begin
			note = notes.pop_front();
			if (note[33])
			begin
				compares++;
				if ({pslverr, prdata} !== note[32:0])
					fail($sformatf("read %h got %h", paddr, prdata));
			end
		end
	end
	// Length of the last conversion phase
	always @(posedge core_clk_in)
	begin
		if (active === 1'b1)
			act_cnt <= act_cnt + 1;
		else if (act_cnt != 0)
		begin
			act_len <= act_cnt;
			act_cnt <= 0;
		end
	end

	// One conversion from a chosen source, then result and flag checks
	task automatic convert(input logic [1:0] mode, input logic tm, input logic lj,
		input logic se, input logic [9:0] code);
		logic [7:0] base, hi, lo;
		logic [15:0] w;
		logic ord, ab, bl, wexp;
		int n;
		base = {1'b1, tm, 2'b00, mode, 1'b0, lj};
		level <= code;
		single_ended <= se;
		wr(IDX_CONV_CTL, base);
		if (!tm)
			chk(track, 10'h1, "idle track");
		if (mode == CM_SOFTWARE)
		begin
			wr(IDX_CONV_CTL, base | 8'h10);
			chk(track, tm, "track at start");
			chk(active, !tm, "convert at start");
			wr(IDX_CONV_CTL, base | 8'h10);
			rchk(IDX_CONV_CTL, base | 8'h10);
		end
		else
			front_u.fire(mode);
		n = 0;
		do
		begin
			rd(ba(IDX_CONV_CTL), 33'h0, 1'b0, q);
			n++;
		end
		while (q[CTL_DONE_BIT] !== 1'b1 && n < 100);
		if (q[CTL_DONE_BIT] !== 1'b1)
		begin
			fail("no done");
			tally_and_finish();
		end
		hi = lj ? code[9:2] : {{6{code[9] & !se}}, code[9:8]};
		lo = lj ? {code[1:0], 6'h00} : code[7:0];
		// Window: ordered limits match inside, reversed match outside
		w = {hi, lo};
		ord = se ? (lt_lim > gt_lim) : ($signed(lt_lim) > $signed(gt_lim));
		ab = se ? (w > gt_lim) : ($signed(w) > $signed(gt_lim));
		bl = se ? (w < lt_lim) : ($signed(w) < $signed(lt_lim));
		wexp = ord ? (ab & bl) : (ab | bl);
		rchk(IDX_RES_HI, hi);
		rchk(IDX_RES_LO, lo);
		rchk(IDX_CONV_CTL, base | 8'h20 | {6'h00, wexp, 1'b0});
		chk(done_irq, 10'h1, "done request");
		chk(win_irq, wexp, "window request");
		chk((act_len >= 37 && act_len <= 40), 10'h1, "convert length");
		$display("test convert mode %0d track %0d finished", mode, tm);
	endtask

	initial
	begin
		resetn_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hf;
		single_ended = 1'b1;
		gt_lim = 16'h0000;
		lt_lim = 16'h0000;
		level = 10'h000;
		n_mismatch = 0;
		compares = 0;
		act_cnt = 0;
		act_len = 0;
		rnd = 32'hb857ce15;
		repeat (10) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		rchk(IDX_CONFIG, CONFIG_RESET);
		rchk(IDX_CONV_CTL, CONV_CTL_RESET);
		rchk(IDX_HV_CTL, HV_CTL_RESET);
		rchk(IDX_RES_HI, RESULT_RESET);
		chk(gsel, 10'h01, "reset gain");
		chk(power, 10'h0, "reset power");
		rd(12'h000, {1'b1, 32'h00000000}, 1'b1, q);
		$display("test reset finished");
		// Every gain code, divider left at three
		for (i = 0; i < 8; i++)
		begin
			wr(IDX_CONFIG, {5'h03, i[2:0]});
			@(posedge core_clk_in);
			#1;
			chk(gsel, (i < 4) ? 10'h1 << i : (i < 6) ? 10'h10 : 10'h20, "pga gain");
		end
		rchk(IDX_CONFIG, 8'h1f);
		// Amplifier control, reserved bits and a strobe-less write
		wr(IDX_HV_CTL, 8'hff);
		rchk(IDX_HV_CTL, 8'h8f);
		chk({hv_en, hv_gain}, 10'h1f, "hv on");
		pstrb <= 4'h0;
		wr(IDX_HV_CTL, 8'h00);
		pstrb <= 4'hf;
		rchk(IDX_HV_CTL, 8'h8f);
		wr(IDX_HV_CTL, 8'h0a);
		chk({hv_en, hv_gain}, 10'h0a, "hv off");
		$display("test amplifier finished");
		// All sources in both tracking modes, random codes and formats
		for (i = 0; i < 8; i++)
		begin
			rnd = lfsr(rnd);
			convert(i[1:0], i[2], rnd[10], rnd[11], (i == 5) ? 10'h000 : rnd[9:0]);
		end
		gt_lim <= 16'h0100;
		lt_lim <= 16'h0300;
		convert(CM_SOFTWARE, 1'b0, 1'b0, 1'b1, 10'h200);
		convert(CM_TIMER_B, 1'b1, 1'b0, 1'b1, 10'h050);
		convert(CM_SOFTWARE, 1'b0, 1'b0, 1'b0, 10'h200);
		// Busy write outside software mode, then abort by disable
		wr(IDX_CONV_CTL, 8'h84);
		wr(IDX_CONV_CTL, 8'h94);
		rchk(IDX_CONV_CTL, 8'h84);
		wr(IDX_CONV_CTL, 8'h90);
		chk(active, 10'h0, "start from mode change");
		wr(IDX_CONV_CTL, 8'h90);
		chk(active, 10'h1, "abort start");
		wr(IDX_CONV_CTL, 8'h00);
		repeat (60) @(posedge core_clk_in);
		rchk(IDX_CONV_CTL, 8'h00);
		chk({power, track}, 10'h0, "shutdown");
		$display("test refusals finished");
		tally_and_finish();
	end
endmodule
